// ==== src/swdmc_top.sv ====
// Notes on behaviour
// - Wake line driven low in Normal, released in Sleep.
// - In Sleep, wake line falling edge moves device to Normal.
// - With logic supply, wake edge wakes only while interrupt line high.
// - Chip select or interrupt edge wakes only with logic supply present.
// - Battery-type input above reference is closed; ground-type inverted.
// - Ground-only input above reference is open, below is closed.
// - Every frame returns switch states, interrupt flag and thermal flag.
// - Chip select fall captures present switch states into shift register.
// - A valid frame has exactly 24 or 48 serial clocks under chip select.
// - Daisy chain uses 48 clocks; data passes through shift register.
// - Supply loss keeps mode; sleep ends only on listed wake sources.
// - Without logic supply serial port and select/interrupt wake ignored.
// - Power-on reset places device in Normal mode.
// - Reset applies battery type, wake on, 16 mA, timer on, tri-state, amux 0.
// - Normal entered on reset, switch change, wake, interrupt, select, timer.
// - Commands accepted only in Normal mode with logic supply.
// - Normal mode accepts settings, wake, wetting, timer, tri, analog, cal, reset.
// - Select rise clears interrupt unless a change occurred during select low.
// - Sample on falling, shift on rising, MSB first, output off when deselected.
// - Command takes effect only at chip select rise after full word.
// - Open switch reports zero, closed switch reports one.
`include "swdmc_defines.svh"

module swdmc_top
    import swdmc_pkg::*;
(
    // Clock and power-on reset
    input wire logic REF_CLK_IN,
    input wire logic RESET_N_IN,
    // Serial port
    input wire logic SCLK_IN,
    input wire logic CS_N_IN,
    input wire logic SI_IN,
    output logic SO_OUT,
    output logic SO_OE_N_OUT,
    // Open-drain wake and interrupt lines
    input wire logic WAKE_N_IN,
    output logic WAKE_N_OUT,
    output logic WAKE_N_OE_N_OUT,
    input wire logic INT_N_IN,
    output logic INT_N_OUT,
    output logic INT_N_OE_N_OUT,
    // Supply and comparator results
    input wire logic LOGIC_SUPPLY_IN,
    input wire logic [7:0] PROG_SWITCH_INPUTS_IN,
    input wire logic [13:0] GROUND_SWITCH_INPUTS_IN,
    // Same-domain events
    input wire logic THERMAL_FLAG_IN,
    input wire logic INT_TIMER_EXPIRED_IN,
    input wire logic SLEEP_REQ_IN,
    // Configuration and mode
    output logic SLEEP_MODE_OUT,
    output logic [7:0] BATT_SELECT_OUT,
    output logic [21:0] WAKE_EN_OUT,
    output logic [21:0] WET_HIGH_OUT,
    output logic [21:0] WET_TIMER_EN_OUT,
    output logic [21:0] TRISTATE_OUT,
    output logic [4:0] ANALOG_SEL_OUT,
    output logic CAL_PULSE_OUT
);

    swdmc_state_t q;
    swdmc_state_t d;

    logic [27:0] raw;
    logic [27:0] ag_nx;
    logic vdd;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    logic wake_fall;
    logic int_fall;
    logic cs_low;
    logic [7:0] sp_closed;
    logic [13:0] sg_closed;
    logic [21:0] cur;
    logic chg;
    logic frame_ok;
    logic [7:0] cmd;

    assign raw = {LOGIC_SUPPLY_IN, INT_N_IN, WAKE_N_IN, SI_IN, CS_N_IN, SCLK_IN,
                  GROUND_SWITCH_INPUTS_IN, PROG_SWITCH_INPUTS_IN};
    // A bit moves only once the second and third stages agree
    assign ag_nx = (q.s2 & q.s3) | (q.ag & (q.s2 | q.s3));

    assign vdd = q.ag[`SWDMC_SYN_VDD];
    assign cs_low = ~q.ag[`SWDMC_SYN_CS];
    // Serial edges are dead while the logic supply is gone
    assign sclk_rise = vdd & cs_low & ~q.ag[`SWDMC_SYN_SCLK] & ag_nx[`SWDMC_SYN_SCLK];
    assign sclk_fall = vdd & cs_low & q.ag[`SWDMC_SYN_SCLK] & ~ag_nx[`SWDMC_SYN_SCLK];
    assign cs_fall = vdd & q.ag[`SWDMC_SYN_CS] & ~ag_nx[`SWDMC_SYN_CS];
    assign cs_rise = vdd & ~q.ag[`SWDMC_SYN_CS] & ag_nx[`SWDMC_SYN_CS];
    assign wake_fall = q.ag[`SWDMC_SYN_WAKE] & ~ag_nx[`SWDMC_SYN_WAKE];
    assign int_fall = q.ag[`SWDMC_SYN_INT] & ~ag_nx[`SWDMC_SYN_INT];

    assign sp_closed = q.ag[7:0] ~^ q.batt;
    assign sg_closed = ~q.ag[21:8];
    assign cur = {sg_closed, sp_closed};
    assign chg = |((cur ^ q.prev) & q.wake_en);

    // Only whole frames count; 48 covers a two-device chain
    assign frame_ok = (q.cnt == `SWDMC_FRAME_BITS) || (q.cnt == `SWDMC_CHAIN_BITS);
    assign cmd = q.sh[`SWDMC_CMD_MSB:`SWDMC_CMD_LSB];

    always_comb begin
        d = q;
        d.s1 = raw;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.ag = ag_nx;
        d.prev = cur;
        d.cal = 1'b0;

        // Interrupt flag; a new change beats the clear
        if (cs_rise) begin
            d.int_pend = q.chg_cs;
            d.chg_cs = 1'b0;
        end
        if (chg) begin
            d.int_pend = 1'b1;
            // A change in the clearing cycle must not linger into the next frame
            if (cs_low && !cs_rise) begin
                d.chg_cs = 1'b1;
            end
        end

        // Serial shifter: one register serves both directions
        if (cs_fall) begin
            d.sh = {cur[7:0], cur[21:8], q.int_pend, THERMAL_FLAG_IN};
            d.cnt = 6'd0;
        end else if (sclk_rise) begin
            d.so = q.sh[23];
        end else if (sclk_fall) begin
            d.sh = {q.sh[22:0], q.ag[`SWDMC_SYN_SI]};
            if (q.cnt != 6'h3F) begin
                d.cnt = q.cnt + 6'd1;
            end
        end

        unique case (q.mode)
            SWDMC_NORMAL: begin
                // Supply loss alone never changes mode
                if (SLEEP_REQ_IN) begin
                    d.mode = SWDMC_SLEEP;
                end
            end
            SWDMC_SLEEP: begin
                if (chg || INT_TIMER_EXPIRED_IN) begin
                    d.mode = SWDMC_NORMAL;
                end
                if (wake_fall && (!vdd || q.ag[`SWDMC_SYN_INT])) begin
                    d.mode = SWDMC_NORMAL;
                end
                if (vdd && int_fall && q.ag[`SWDMC_SYN_WAKE]) begin
                    d.mode = SWDMC_NORMAL;
                end
                if (cs_fall) begin
                    d.mode = SWDMC_NORMAL;
                end
            end
        endcase

        // Command decode at select rise
        if (cs_rise && frame_ok && q.mode == SWDMC_NORMAL) begin
            unique case (cmd)
                `SWDMC_CMD_SETTINGS: d.batt = q.sh[7:0];
                `SWDMC_CMD_WAKE_SP: d.wake_en[7:0] = q.sh[7:0];
                `SWDMC_CMD_WAKE_SG: d.wake_en[21:8] = q.sh[13:0];
                `SWDMC_CMD_METAL_SP: d.wet_hi[7:0] = q.sh[7:0];
                `SWDMC_CMD_METAL_SG: d.wet_hi[21:8] = q.sh[13:0];
                `SWDMC_CMD_TIMER_SP: d.tmr_en[7:0] = q.sh[7:0];
                `SWDMC_CMD_TIMER_SG: d.tmr_en[21:8] = q.sh[13:0];
                `SWDMC_CMD_TRI_SP: d.tris[7:0] = q.sh[7:0];
                `SWDMC_CMD_TRI_SG: d.tris[21:8] = q.sh[13:0];
                `SWDMC_CMD_ANALOG: d.amux = q.sh[4:0];
                `SWDMC_CMD_CALIB: d.cal = 1'b1;
                `SWDMC_CMD_RESET: begin
                    d.batt = `SWDMC_RST_BATT;
                    d.wake_en = `SWDMC_RST_ALL22;
                    d.wet_hi = `SWDMC_RST_ALL22;
                    d.tmr_en = `SWDMC_RST_ALL22;
                    d.tris = `SWDMC_RST_ALL22;
                    d.amux = `SWDMC_RST_AMUX;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (!RESET_N_IN) begin
            q.mode <= SWDMC_NORMAL;
            // Idle levels so no false edge is seen after release
            q.s1 <= {28{1'b1}};
            q.s2 <= {28{1'b1}};
            q.s3 <= {28{1'b1}};
            q.ag <= {28{1'b1}};
            q.sh <= 24'h000000;
            q.so <= 1'b0;
            q.cnt <= 6'd0;
            q.prev <= 22'h000000;
            q.int_pend <= 1'b0;
            q.chg_cs <= 1'b0;
            q.batt <= `SWDMC_RST_BATT;
            q.wake_en <= `SWDMC_RST_ALL22;
            q.wet_hi <= `SWDMC_RST_ALL22;
            q.tmr_en <= `SWDMC_RST_ALL22;
            q.tris <= `SWDMC_RST_ALL22;
            q.amux <= `SWDMC_RST_AMUX;
            q.cal <= 1'b0;
        end else begin
            q <= d;
        end
    end

    assign SO_OUT = q.so;
    assign SO_OE_N_OUT = ~(cs_low & vdd);
    assign WAKE_N_OUT = 1'b0;
    assign WAKE_N_OE_N_OUT = (q.mode != SWDMC_NORMAL);
    assign INT_N_OUT = 1'b0;
    assign INT_N_OE_N_OUT = ~q.int_pend;
    assign SLEEP_MODE_OUT = (q.mode == SWDMC_SLEEP);
    assign BATT_SELECT_OUT = q.batt;
    assign WAKE_EN_OUT = q.wake_en;
    assign WET_HIGH_OUT = q.wet_hi;
    assign WET_TIMER_EN_OUT = q.tmr_en;
    assign TRISTATE_OUT = q.tris;
    assign ANALOG_SEL_OUT = q.amux;
    assign CAL_PULSE_OUT = q.cal;

endmodule

// ==== pkg/swdmc_defines.svh ====
`ifndef SWDMC_DEFINES_SVH
`define SWDMC_DEFINES_SVH

// Frame length and command field
`define SWDMC_FRAME_BITS 6'd24
`define SWDMC_CHAIN_BITS 6'd48
`define SWDMC_CMD_MSB 23
`define SWDMC_CMD_LSB 16

// Command codes
`define SWDMC_CMD_SETTINGS 8'h01
`define SWDMC_CMD_WAKE_SP 8'h02
`define SWDMC_CMD_WAKE_SG 8'h03
`define SWDMC_CMD_METAL_SP 8'h04
`define SWDMC_CMD_METAL_SG 8'h05
`define SWDMC_CMD_TIMER_SP 8'h07
`define SWDMC_CMD_TIMER_SG 8'h08
`define SWDMC_CMD_TRI_SP 8'h09
`define SWDMC_CMD_TRI_SG 8'h0A
`define SWDMC_CMD_ANALOG 8'h0C
`define SWDMC_CMD_CALIB 8'h0D
`define SWDMC_CMD_RESET 8'h7F

// Positions in the synchronised input vector
`define SWDMC_SYN_W 28
`define SWDMC_SYN_SCLK 22
`define SWDMC_SYN_CS 23
`define SWDMC_SYN_SI 24
`define SWDMC_SYN_WAKE 25
`define SWDMC_SYN_INT 26
`define SWDMC_SYN_VDD 27

// Defaults after power-on or reset command
`define SWDMC_RST_BATT 8'hFF
`define SWDMC_RST_ALL22 22'h3FFFFF
`define SWDMC_RST_AMUX 5'h00

`endif

// ==== pkg/swdmc_pkg.sv ====
package swdmc_pkg;

    typedef enum logic [1:0] {
        SWDMC_NORMAL = 2'b01,
        SWDMC_SLEEP = 2'b10
    } swdmc_mode_t;

    typedef struct packed {
        swdmc_mode_t mode;
        logic [27:0] s1;
        logic [27:0] s2;
        logic [27:0] s3;
        logic [27:0] ag;
        logic [23:0] sh;
        logic so;
        logic [5:0] cnt;
        logic [21:0] prev;
        logic int_pend;
        logic chg_cs;
        logic [7:0] batt;
        logic [21:0] wake_en;
        logic [21:0] wet_hi;
        logic [21:0] tmr_en;
        logic [21:0] tris;
        logic [4:0] amux;
        logic cal;
    } swdmc_state_t;

endpackage

// ==== test/swdmc_host_model.sv ====
module swdmc_host_model (
    input wire logic clk,
    input wire logic so,
    output logic sclk = 1'b0,
    output logic cs_n = 1'b1,
    output logic si = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    // 8 clocks a bit gives 320 ns, well under the serial clock ceiling
    task automatic xfer(input logic [47:0] w, input int n, output logic [47:0] r);
        r = '0;
        @(posedge clk) cs_n <= 1'b0;
        repeat (8) @(posedge clk);
        for (int i = n - 1; i >= 0; i--) begin
            sclk <= 1'b1;
            si <= w[i];
            repeat (4) @(posedge clk);
            sclk <= 1'b0;
            repeat (4) @(posedge clk);
            r = {r[46:0], so};
        end
        cs_n <= 1'b1;
        si <= ~si;
        repeat (10) @(posedge clk);
    endtask
endmodule

// ==== test/swdmc_top_assertions.sv ====
module swdmc_top_assertions (
    // Clock and reset
    input wire logic REF_CLK_IN,
    input wire logic RESET_N_IN,
    // Pins and mode
    input wire logic CS_N_IN,
    input wire logic SO_OE_N_OUT,
    input wire logic WAKE_N_IN,
    input wire logic WAKE_N_OUT,
    input wire logic WAKE_N_OE_N_OUT,
    input wire logic INT_N_IN,
    input wire logic INT_N_OUT,
    input wire logic INT_N_OE_N_OUT,
    input wire logic LOGIC_SUPPLY_IN,
    input wire logic INT_TIMER_EXPIRED_IN,
    input wire logic SLEEP_MODE_OUT,
    // Configuration
    input wire logic [7:0] BATT_SELECT_OUT,
    input wire logic [21:0] WAKE_EN_OUT,
    input wire logic [21:0] WET_HIGH_OUT,
    input wire logic [21:0] WET_TIMER_EN_OUT,
    input wire logic [21:0] TRISTATE_OUT,
    input wire logic [4:0] ANALOG_SEL_OUT,
    input wire logic CAL_PULSE_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    wire [100:0] cfg = {BATT_SELECT_OUT, WAKE_EN_OUT, WET_HIGH_OUT, WET_TIMER_EN_OUT,
        TRISTATE_OUT, ANALOG_SEL_OUT};
    default clocking @(posedge REF_CLK_IN);
    endclocking
    default disable iff (!RESET_N_IN);
    AST_WAKE_DRIVE: assert property (WAKE_N_OE_N_OUT == SLEEP_MODE_OUT
        && !WAKE_N_OUT && !INT_N_OUT) else $error("wake drive wrong");
    AST_POR: assert property ($rose(RESET_N_IN) |-> !SLEEP_MODE_OUT && INT_N_OE_N_OUT
        && cfg == {8'hFF, {88{1'b1}}, 5'h00}) else $error("reset defaults wrong");
    AST_SO_OFF: assert property (CS_N_IN [*7] |-> SO_OE_N_OUT)
        else $error("SO driven while deselected");
    AST_SO_ON: assert property ((!CS_N_IN && LOGIC_SUPPLY_IN) [*7] |-> !SO_OE_N_OUT)
        else $error("SO not driven while selected");
    AST_CFG_AT_CS: assert property (!$stable(cfg) || CAL_PULSE_OUT |-> CS_N_IN
        && !$past(CS_N_IN, 8) && LOGIC_SUPPLY_IN && !SLEEP_MODE_OUT)
        else $error("config changed outside select rise");
    AST_INT_CLEAR: assert property ($rose(INT_N_OE_N_OUT) |-> CS_N_IN && !$past(CS_N_IN, 8))
        else $error("interrupt cleared outside select rise");
    AST_WAKE_EDGE: assert property (SLEEP_MODE_OUT && $fell(WAKE_N_IN) && INT_N_IN
        |-> ##[1:8] !SLEEP_MODE_OUT) else $error("wake edge ignored");
    AST_TIMER_WAKE: assert property (SLEEP_MODE_OUT && INT_TIMER_EXPIRED_IN
        |-> ##[1:2] !SLEEP_MODE_OUT) else $error("timer wake ignored");
endmodule

bind swdmc_top swdmc_top_assertions swdmc_top_assertions_i (.*);

// ==== test/test_switch_detect_mode_control.sv ====
module test_switch_detect_mode_control;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [100:0] DEF = {8'hFF, {88{1'b1}}, 5'h00};
    logic clk = 0, rst_n = 0, wk_x = 1, in_x = 1, sup = 1, th = 1, tmr = 0, slp = 0;
    logic [7:0] sp = 8'hA5;
    logic [13:0] sg = 14'h1234;
    logic sclk, cs_n, si, so, wk_oe, in_oe, slp_o, cal;
    logic [7:0] batt;
    logic [21:0] wk, wet, te, ts;
    logic [4:0] am;
    logic [47:0] r;
    logic [100:0] e;
    int err_total = 0;
    int check_count = 0;
    int cals = 0;
    // Open-drain lines: pulled high unless either side pulls low
    wire wk_n = wk_oe ? wk_x : 1'b0;
    wire in_n = in_oe ? in_x : 1'b0;
    wire [100:0] cfg = {batt, wk, wet, te, ts, am};
    always #20 clk = ~clk;
    always @(posedge clk) if (cal === 1'b1) cals++;
    swdmc_top swdmc_top_i (.REF_CLK_IN(clk), .RESET_N_IN(rst_n), .SCLK_IN(sclk),
        .CS_N_IN(cs_n), .SI_IN(si), .SO_OUT(so), .SO_OE_N_OUT(), .WAKE_N_IN(wk_n),
        .WAKE_N_OUT(), .WAKE_N_OE_N_OUT(wk_oe), .INT_N_IN(in_n), .INT_N_OUT(),
        .INT_N_OE_N_OUT(in_oe), .LOGIC_SUPPLY_IN(sup), .PROG_SWITCH_INPUTS_IN(sp),
        .GROUND_SWITCH_INPUTS_IN(sg), .THERMAL_FLAG_IN(th), .INT_TIMER_EXPIRED_IN(tmr),
        .SLEEP_REQ_IN(slp), .SLEEP_MODE_OUT(slp_o), .BATT_SELECT_OUT(batt), .WAKE_EN_OUT(wk),
        .WET_HIGH_OUT(wet), .WET_TIMER_EN_OUT(te), .TRISTATE_OUT(ts), .ANALOG_SEL_OUT(am),
        .CAL_PULSE_OUT(cal));
    swdmc_host_model swdmc_host_model_i (.clk(clk), .so(so), .sclk(sclk), .cs_n(cs_n), .si(si));
    task automatic chk(input logic [159:0] s, input logic [159:0] x);
        check_count++;
        if (s !== x) begin
            err_total++;
            $display("MISMATCH %0t %h %h", $time, s, x);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic go(input logic [47:0] w, input int n = 24);
        swdmc_host_model_i.xfer(w, n, r);
    endtask
    function automatic logic [23:0] st(input logic p);
        return {~(sp ^ e[100:93]), ~sg, p, th};
    endfunction
    task automatic cmd(input logic [23:0] w);
        go(w);
        case (w[23:16])
            8'h01: e[100:93] = w[7:0];
            8'h02: e[78:71] = w[7:0];
            8'h03: e[92:79] = w[13:0];
            8'h04: e[56:49] = w[7:0];
            8'h05: e[70:57] = w[13:0];
            8'h07: e[34:27] = w[7:0];
            8'h08: e[48:35] = w[13:0];
            8'h09: e[12:5] = w[7:0];
            8'h0A: e[26:13] = w[13:0];
            8'h0C: e[4:0] = w[4:0];
            8'h7F: e = DEF;
            default: ;
        endcase
        chk(cfg, e);
    endtask
    task automatic nap();
        slp <= 1'b1;
        cyc(1);
        slp <= 1'b0;
        cyc(12);
    endtask
    task automatic t_status();
        chk({cfg, slp_o, wk_oe}, {DEF, 2'b00});
        cmd(24'h01000F);
        chk(in_oe, 1'b0);
        go(0);
        chk(r[23:0], st(1'b1));
        chk(in_oe, 1'b1);
        fork
            go(0);
            begin
                cyc(40);
                sp <= 8'hA4;
            end
        join
        chk(in_oe, 1'b0);
        go(0);
        chk(r[23:0], st(1'b1));
    endtask
    task automatic t_cmds();
        logic [23:0] t[12] = '{24'h023C5A, 24'h032AAA, 24'h0400C3, 24'h051555, 24'h07000F,
            24'h0831F0, 24'h0900AA, 24'h0A0F0F, 24'h0C0015, 24'h06FFFF, 24'h0D0000, 24'h7F0000};
        go(24'h0C001F, 23);
        chk(cfg, e);
        th <= 1'b0;
        go({24'h5A5A5A, 24'h0C0007}, 48);
        e[4:0] = 5'h07;
        chk({r, cfg}, {st(1'b0), 24'h5A5A5A, e});
        foreach (t[i]) cmd(t[i]);
        chk(cals, 1);
    endtask
    task automatic t_sleep();
        go(0);
        chk(in_oe, 1'b1);
        nap();
        chk({slp_o, wk_oe}, 2'b11);
        wk_x <= 1'b0;
        cyc(12);
        wk_x <= 1'b1;
        chk({slp_o, wk_oe}, 2'b00);
        in_x <= 1'b0;
        nap();
        wk_x <= 1'b0;
        cyc(12);
        wk_x <= 1'b1;
        chk(slp_o, 1'b1);
        in_x <= 1'b1;
        cyc(12);
        in_x <= 1'b0;
        cyc(12);
        in_x <= 1'b1;
        chk(slp_o, 1'b0);
        nap();
        go(0);
        chk(slp_o, 1'b0);
        nap();
        sp <= 8'hA5;
        cyc(12);
        chk(slp_o, 1'b0);
        nap();
        sup <= 1'b0;
        cyc(8);
        go(24'h0C001F);
        chk({slp_o, cfg}, {1'b1, e});
        tmr <= 1'b1;
        cyc(1);
        tmr <= 1'b0;
        cyc(4);
        chk(slp_o, 1'b0);
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        cyc(30000);
        err_total++;
        conclude();
    end
    initial begin
        e = DEF;
        cyc(3);
        rst_n <= 1'b1;
        cyc(8);
        t_status();
        t_cmds();
        t_sleep();
        conclude();
    end
endmodule
